//--- design/bus_cycle.v
// one read or write cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
`include "toggle_poll_defs.vh"
module bus_cycle #(
  parameter AW = 21
) (
  input  wire          ref_clk,
  input  wire          rst,
  input  wire          go,
  input  wire          wr,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  input  wire [7:0]    dq_in,
  output reg  [AW-1:0] addr_reg,
  output reg           ce_n_reg,
  output reg           oe_n_reg,
  output reg           we_n_reg,
  output reg  [7:0]    dq_out_reg,
  output reg           dq_oe_n_reg,
  output reg  [7:0]    rdata_reg,
  output reg           done_reg
);
  localparam integer STROBE_INT  = (`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer RECOVER_INT = (`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [7:0]   STROBE_CYC  = STROBE_INT[7:0];
  localparam [7:0]   RECOVER_CYC = RECOVER_INT[7:0];
  localparam [1:0] P_IDLE = 2'h0;
  localparam [1:0] P_STRB = 2'h1;
  localparam [1:0] P_RECV = 2'h2;

  reg [1:0] ph_reg;
  reg [7:0] cnt_reg;
  reg       wr_reg;
  reg [7:0] s1_reg;
  reg [7:0] s2_reg;
  reg [7:0] s3_reg;

  ////////////////////////////////////////////////////////////////////////
  // data pins are asynchronous to ref_clk
  always @(posedge ref_clk) begin
    s1_reg <= dq_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (rst) begin
      ph_reg      <= P_IDLE;
      cnt_reg     <= 8'h00;
      wr_reg      <= 1'b0;
      addr_reg    <= {AW{1'b0}};
      ce_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      dq_out_reg  <= 8'h00;
      dq_oe_n_reg <= 1'b1;
      rdata_reg   <= 8'h00;
      done_reg    <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (ph_reg)
        P_IDLE: begin
          if (go) begin
            ph_reg      <= P_STRB;
            cnt_reg     <= STROBE_CYC;
            wr_reg      <= wr;
            addr_reg    <= addr;
            ce_n_reg    <= 1'b0;
            oe_n_reg    <= wr;
            we_n_reg    <= ~wr;
            dq_out_reg  <= wdata;
            dq_oe_n_reg <= ~wr;
          end
        end
        P_STRB: begin
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          // capture only once the last two stages agree, or at once on a write
          end else if (wr_reg || (s2_reg == s3_reg)) begin
            rdata_reg <= s3_reg;
            oe_n_reg  <= 1'b1;
            we_n_reg  <= 1'b1;
            ph_reg    <= P_RECV;
            cnt_reg   <= RECOVER_CYC;
          end
        end
        P_RECV: begin
          // data held past we_n rise so the device latches it cleanly
          ce_n_reg    <= 1'b1;
          dq_oe_n_reg <= 1'b1;
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            ph_reg   <= P_IDLE;
            done_reg <= 1'b1;
          end
        end
        default: begin
          ph_reg <= P_IDLE;
        end
      endcase
    end
  end
endmodule // bus_cycle
`default_nettype wire

//--- design/toggle_poll.v
// host controller running the toggle-bit status algorithm on a parallel flash
`timescale 1ns/1ns
`default_nettype none
`include "toggle_poll_defs.vh"
module toggle_poll #(
  parameter        AW        = 21,
  parameter [15:0] MAX_POLLS = `MAX_POLLS
) (
  input  wire          ref_clk,
  input  wire          rst,
  input  wire          poll_start,
  input  wire          poll_abort,
  input  wire          dq3_start,
  input  wire [AW-1:0] poll_addr,
  output reg           poll_busy_reg,
  output reg           poll_done_reg,
  output reg           poll_pass_reg,
  output reg           poll_fail_reg,
  output reg           poll_timeout_reg,
  output reg           sector_toggle_reg,
  output reg           erase_window_open_reg,
  output reg           dq3_valid_reg,
  output reg  [7:0]    status_byte_reg,
  output reg           device_busy_reg,
  output wire [AW-1:0] flash_addr,
  output wire          flash_ce_n,
  output wire          flash_oe_n,
  output wire          flash_we_n,
  output wire [7:0]    flash_dq_out,
  output wire          flash_dq_oe_n,
  input  wire [7:0]    flash_dq_in,
  input  wire          ready_busy_out_n
);
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_RD1   = 4'h1;
  localparam [3:0] S_RD2   = 4'h2;
  localparam [3:0] S_EVAL  = 4'h3;
  localparam [3:0] S_RCHK  = 4'h4;
  localparam [3:0] S_RCHK2 = 4'h5;
  localparam [3:0] S_RESET = 4'h6;
  localparam [3:0] S_DQ3   = 4'h7;
  localparam [3:0] S_FIN   = 4'h8;

  reg [3:0]    state_reg;
  reg          issued_reg;
  reg          go_reg;
  reg          wr_reg;
  reg [AW-1:0] addr_reg;
  reg [7:0]    first_reg;
  reg [7:0]    second_reg;
  reg [15:0]   polls_reg;
  reg          abort_reg;
  reg          pass_next;
  reg          fail_next;
  reg          rb1_reg;
  reg          rb2_reg;
  reg          rb3_reg;

  wire         eng_done;
  wire [7:0]   eng_rdata;

  function toggled;
    input [7:0] a;
    input [7:0] b;
    input [2:0] pos;
    begin
      toggled = a[pos] ^ b[pos];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  bus_cycle #(
    .AW (AW)
  ) u_cycle (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .go          (go_reg),
    .wr          (wr_reg),
    .addr        (addr_reg),
    .wdata       (`RESET_CMD),
    .dq_in       (flash_dq_in),
    .addr_reg    (flash_addr),
    .ce_n_reg    (flash_ce_n),
    .oe_n_reg    (flash_oe_n),
    .we_n_reg    (flash_we_n),
    .dq_out_reg  (flash_dq_out),
    .dq_oe_n_reg (flash_dq_oe_n),
    .rdata_reg   (eng_rdata),
    .done_reg    (eng_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // busy pin sync
  always @(posedge ref_clk) begin
    rb1_reg <= ready_busy_out_n;
    rb2_reg <= rb1_reg;
    rb3_reg <= rb2_reg;
    if (rst) begin
      device_busy_reg <= 1'b0;
    end else if (rb2_reg == rb3_reg) begin
      device_busy_reg <= ~rb3_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    pass_next = 1'b0;
    fail_next = 1'b0;
    if (!toggled(first_reg, second_reg, `BIT_OP_TOGGLE)) begin
      pass_next = 1'b1;
    // timeout flag with toggle still running
    end else if (second_reg[`BIT_TIMEOUT]) begin
      fail_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg             <= S_IDLE;
      issued_reg            <= 1'b0;
      go_reg                <= 1'b0;
      wr_reg                <= 1'b0;
      addr_reg              <= {AW{1'b0}};
      first_reg             <= 8'h00;
      second_reg            <= 8'h00;
      polls_reg             <= 16'h0000;
      abort_reg             <= 1'b0;
      poll_busy_reg         <= 1'b0;
      poll_done_reg         <= 1'b0;
      poll_pass_reg         <= 1'b0;
      poll_fail_reg         <= 1'b0;
      poll_timeout_reg      <= 1'b0;
      sector_toggle_reg     <= 1'b0;
      erase_window_open_reg <= 1'b0;
      dq3_valid_reg         <= 1'b0;
      status_byte_reg       <= 8'h00;
    end else begin
      go_reg        <= 1'b0;
      poll_done_reg <= 1'b0;
      if (poll_abort && state_reg != S_IDLE && state_reg != S_RESET) begin
        abort_reg <= 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          abort_reg <= 1'b0;
          // every poll start begins with a fresh double read
          // caller supplies an address in a selected sector
          if (poll_start) begin
            state_reg        <= S_RD1;
            addr_reg         <= poll_addr;
            wr_reg           <= 1'b0;
            polls_reg        <= 16'h0000;
            poll_busy_reg    <= 1'b1;
            poll_pass_reg    <= 1'b0;
            poll_fail_reg    <= 1'b0;
            poll_timeout_reg <= 1'b0;
          // timer bit read only on request
          // single status read of the erase timer bit
          end else if (dq3_start) begin
            state_reg     <= S_DQ3;
            addr_reg      <= poll_addr;
            wr_reg        <= 1'b0;
            poll_busy_reg <= 1'b1;
            dq3_valid_reg <= 1'b0;
          end
        end
        S_RD1, S_RD2, S_RCHK, S_RCHK2, S_DQ3, S_RESET: begin
          if (!issued_reg && abort_reg && state_reg != S_RESET) begin
            state_reg <= S_FIN;
          end else if (!issued_reg) begin
            go_reg     <= 1'b1;
            issued_reg <= 1'b1;
          end else if (eng_done) begin
            issued_reg      <= 1'b0;
            status_byte_reg <= eng_rdata;
            case (state_reg)
              S_RD1: begin
                first_reg <= eng_rdata;
                state_reg <= S_RD2;
              end
              S_RD2: begin
                second_reg <= eng_rdata;
                polls_reg  <= polls_reg + 16'h0001;
                state_reg  <= S_EVAL;
              end
              S_RCHK: begin
                first_reg <= eng_rdata;
                state_reg <= S_RCHK2;
              end
              S_RCHK2: begin
                if (toggled(first_reg, eng_rdata, `BIT_OP_TOGGLE)) begin
                  poll_fail_reg <= 1'b1;
                  wr_reg        <= 1'b1;
                  addr_reg      <= `RESET_ADDR;
                  state_reg     <= S_RESET;
                end else begin
                  poll_pass_reg <= 1'b1;
                  state_reg     <= S_FIN;
                end
              end
              S_DQ3: begin
                // 0 while more sector erases are accepted
                erase_window_open_reg <= ~eng_rdata[`BIT_ERASE_TMR];
                dq3_valid_reg         <= 1'b1;
                state_reg             <= S_FIN;
              end
              default: begin
                wr_reg    <= 1'b0;
                state_reg <= S_FIN;
              end
            endcase
          end
        end
        S_EVAL: begin
          // bit 2 shows whether this sector is selected for erase
          sector_toggle_reg <= toggled(first_reg, second_reg, `BIT_SECT_TOG);
          if (pass_next) begin
            poll_pass_reg <= 1'b1;
            state_reg     <= S_FIN;
          end else if (fail_next) begin
            state_reg <= S_RCHK;
          end else if (abort_reg) begin
            state_reg <= S_FIN;
          end else if (polls_reg >= MAX_POLLS) begin
            // limit hit: caller must restart from the top
            poll_timeout_reg <= 1'b1;
            state_reg        <= S_FIN;
          end else begin
            first_reg <= second_reg;
            state_reg <= S_RD2;
          end
        end
        S_FIN: begin
          poll_busy_reg <= 1'b0;
          poll_done_reg <= 1'b1;
          abort_reg     <= 1'b0;
          state_reg     <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // toggle_poll
`default_nettype wire

//--- design/toggle_poll_defs.vh
// constants for the host-side toggle status poller
// Notes on behaviour
// - host reads whole byte twice and compares toggle bit; unchanged means done.
// - toggling with bit 5 high: recheck; still toggling means failure, send reset.
// - host that pauses polling restarts from the first double read.
// - after a bit 5 failure the host writes the reset command.
// - host may skip bit 3 if sector commands come under 50 us apart.
// - host confirms acceptance, then reads bit 3 around each sector erase.
// - host gives a valid address when reading bit 7 or bit 2 status.
`ifndef TOGGLE_POLL_DEFS_VH
`define TOGGLE_POLL_DEFS_VH

`define CLK_PERIOD_NS 100
`define STROBE_NS     400
`define RECOVER_NS    100

`define BIT_OP_TOGGLE  3'h6
`define BIT_TIMEOUT    3'h5
`define BIT_ERASE_TMR  3'h3
`define BIT_SECT_TOG   3'h2

`define RESET_CMD      8'hF0
`define RESET_ADDR     21'h000000
`define MAX_POLLS      16'hFFFF

`endif

//--- sim/flash_status_model.sv
// behavioural status side of the parallel flash
`timescale 1ns/1ns
`default_nettype none
module flash_status_model (
  input  wire logic [20:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe_n,
  output logic      [7:0]  dq_in,
  output logic             ready_busy_out_n,
  input  wire logic        arm,
  input  wire logic [31:0] busy_reads,
  input  wire logic        over_limit,
  input  wire logic        tmr_done,
  output int               n_wr
);
  int   left = 0;
  logic t6 = 1'b0;
  logic t2 = 1'b0;
  logic dq5 = 1'b0;
  logic [7:0] last = 8'h00;
  wire  act = (left > 0) || dq5;
  // array byte keeps bits 6 and 2 equal and bit 5 low, so a finished pair reads clean
  wire  [7:0] rd_val = act ? {1'b0, t6, dq5, 1'b0, tmr_done, t2, 2'h0} : 8'h5C;
  initial n_wr = 0;
  // only an over-limit run raises bit 5
  always @(posedge arm) begin
    left = busy_reads;
    dq5 = over_limit;
  end
  // flags invert per read while active: for a counted run, or until the reset command on a bit 5 run
  always @(posedge oe_n) begin
    if (!ce_n && we_n) begin
      last = rd_val;
      if (act) begin
        t6 = ~t6;
        t2 = ~t2;
        if (left > 0) left = left - 1;
      end
    end
  end
  // reset command ends a failed routine
  always @(posedge we_n) begin
    if (!ce_n && !dq_oe_n && dq_out == 8'hF0) begin
      n_wr = n_wr + 1;
      dq5 = 1'b0;
      left = 0;
    end
  end
  // during a read, status byte while active and array data otherwise; last read byte inverted between reads
  always @* begin
    if (!ce_n && !oe_n && we_n)
      dq_in = rd_val;
    else
      dq_in = ~last;
  end
  assign ready_busy_out_n = act ? 1'b0 : 1'b1;
endmodule // flash_status_model
`default_nettype wire

//--- sim/toggle_poll_sva.sv
// port checker for the toggle status poller
`timescale 1ns/1ns
`default_nettype none
module toggle_poll_sva #(
  parameter AW = 21
) (
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          poll_start,
  input wire logic          poll_busy_reg,
  input wire logic          poll_done_reg,
  input wire logic          device_busy_reg,
  input wire logic [AW-1:0] flash_addr,
  input wire logic          flash_ce_n,
  input wire logic          flash_oe_n,
  input wire logic          flash_we_n,
  input wire logic [7:0]    flash_dq_out,
  input wire logic          flash_dq_oe_n,
  input wire logic          ready_busy_out_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_done_pulse: assert property (poll_done_reg |=> !poll_done_reg)
    else $error("done longer than one cycle");
  chk_start_busy: assert property (poll_start && !poll_busy_reg && !poll_done_reg
    |=> poll_busy_reg) else $error("start not taken");
  chk_done_idle: assert property (poll_done_reg |-> !poll_busy_reg && flash_ce_n
    && flash_oe_n && flash_we_n && flash_dq_oe_n) else $error("bus busy at done");
  chk_oe_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*4])
    else $error("read strobe short");
  chk_no_clash: assert property (!flash_oe_n |-> flash_we_n && flash_dq_oe_n)
    else $error("drive during read");
  chk_addr_hold: assert property (!flash_oe_n && !$past(flash_oe_n)
    |-> $stable(flash_addr)) else $error("address moved in read");
  chk_reset_cmd: assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n
    && flash_dq_out == 8'hF0 && flash_addr == '0) else $error("bad reset write");
  chk_rdy_sync: assert property ($fell(ready_busy_out_n) |-> ##[1:6] device_busy_reg)
    else $error("busy not seen");
endmodule // toggle_poll_sva
`default_nettype wire

//--- sim/toggle_poll_tb.sv
// self-checking bench for the toggle status poller
`timescale 1ns/1ns
`default_nettype none
module toggle_poll_tb;
  logic ref_clk = 1'b0, rst = 1'b1, poll_start = 1'b0, poll_abort = 1'b0;
  logic dq3_start = 1'b0, arm = 1'b0, over_limit = 1'b0, tmr_done = 1'b0;
  logic [20:0] poll_addr = 21'h000000;
  logic [7:0]  lf = 8'h26;
  int          busy_reads = 0, n_wr, n_errors = 0, n_tests = 0, nb, w0;
  wire [20:0] flash_addr;
  wire [7:0]  flash_dq_out, flash_dq_in, sbyte;
  wire        ce_n, oe_n, we_n, dq_oe_n, rb_n, pass, fail, tmo, sect, win, vld, dbusy, done;
  always #50 ref_clk = ~ref_clk;
  toggle_poll #(.AW(21), .MAX_POLLS(16'h0004)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .poll_start(poll_start), .poll_abort(poll_abort), .dq3_start(dq3_start),
    .poll_addr(poll_addr), .poll_busy_reg(), .poll_done_reg(done),
    .poll_pass_reg(pass), .poll_fail_reg(fail), .poll_timeout_reg(tmo),
    .sector_toggle_reg(sect), .erase_window_open_reg(win), .dq3_valid_reg(vld),
    .status_byte_reg(sbyte), .device_busy_reg(dbusy), .flash_addr(flash_addr),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(dq_oe_n),
    .flash_dq_in(flash_dq_in), .ready_busy_out_n(rb_n));
  flash_status_model i_flash (.addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .dq_out(flash_dq_out), .dq_oe_n(dq_oe_n), .dq_in(flash_dq_in),
    .ready_busy_out_n(rb_n), .arm(arm), .busy_reads(busy_reads),
    .over_limit(over_limit), .tmr_done(tmr_done), .n_wr(n_wr));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cmp_bits(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: flags %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic setup(input int n, input logic ol, input logic td);
    @(posedge ref_clk);
    busy_reads <= n;
    over_limit <= ol;
    tmr_done <= td;
    arm <= 1'b1;
    @(posedge ref_clk);
    arm <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  // one request, then wait for done; ab raises abort after ten cycles
  task automatic run(input logic s, input logic ab);
    int k;
    lf = nxt(lf);
    @(posedge ref_clk);
    poll_start <= s;
    dq3_start <= !s;
    poll_addr <= {13'h0000, lf};
    @(posedge ref_clk);
    poll_start <= 1'b0;
    dq3_start <= 1'b0;
    for (k = 0; k < 4000 && done !== 1'b1; k++) begin
      @(posedge ref_clk);
      if (k == 10 && ab) poll_abort <= 1'b1;
      @(negedge ref_clk);
    end
    cmp_cnt(k < 4000, 1);
    @(posedge ref_clk);
    poll_abort <= 1'b0;
  endtask
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      nb = lf % 3;
      setup(nb, 1'b0, 1'b0);
      @(negedge ref_clk);
      cmp_cnt(dbusy, nb > 0);
      run(1'b1, 1'b0);
      cmp_bits({pass, fail, tmo, sect}, 4'b1000);
      cmp_cnt(sbyte, 8'h5C);
    end
    w0 = n_wr;
    setup(0, 1'b1, 1'b0);
    run(1'b1, 1'b0);
    cmp_bits({pass, fail, tmo, sect}, 4'b0101);
    cmp_cnt(n_wr, w0 + 1);
    setup(200, 1'b0, 1'b0);
    run(1'b1, 1'b0);
    cmp_bits({pass, fail, tmo, sect}, 4'b0011);
    for (int t = 0; t < 2; t++) begin
      setup(200, 1'b0, t[0]);
      run(1'b0, 1'b0);
      cmp_bits({2'b00, win, vld}, {2'b00, ~t[0], 1'b1});
    end
    run(1'b1, 1'b1);
    // the pair read before the abort still reports its bit 2 change
    cmp_bits({pass, fail, tmo, sect}, 4'b0001);
    complete_run;
  end
  initial begin
    #(100 * 60000);
    n_errors++;
    complete_run;
  end
endmodule // toggle_poll_tb
bind toggle_poll toggle_poll_sva #(.AW(AW)) i_sva (.ref_clk(ref_clk), .rst(rst),
  .poll_start(poll_start), .poll_busy_reg(poll_busy_reg), .poll_done_reg(poll_done_reg),
  .device_busy_reg(device_busy_reg), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n(flash_dq_oe_n), .ready_busy_out_n(ready_busy_out_n));
`default_nettype wire
